// ### pkg/psr_pkg.sv
package psr_pkg;

    // =====================================================================
    // access and register numbers
    // =====================================================================
    localparam int DATA_W = 32;
    localparam logic [7:0] RES_TYPE_PS = 8'h0C;
    localparam logic [7:0] REG_RAM_BASE = 8'h00;
    localparam logic [7:0] REG_VEC_BASE = 8'h01;
    localparam logic [7:0] REG_TILE_CTL = 8'h02;
    localparam logic [7:0] REG_BOOT_STAT = 8'h03;
    localparam logic [7:0] REG_SEC_CFG = 8'h05;
    localparam logic [7:0] REG_RO_CTL = 8'h06;
    localparam logic [7:0] REG_RO_CORE_CELL = 8'h07;
    localparam logic [7:0] REG_RO_CORE_WIRE = 8'h08;
    localparam logic [7:0] REG_RO_PERI_CELL = 8'h09;
    localparam logic [7:0] REG_RO_PERI_WIRE = 8'h0A;

    // =====================================================================
    // reset values and writable masks
    // =====================================================================
    localparam logic [31:0] RAM_BASE_RST = 32'h0004_0000;
    localparam logic [31:0] RAM_BASE_MASK = 32'hFFFF_FFFC;
    localparam logic [31:0] VEC_BASE_RST = 32'h0000_0000;
    localparam logic [31:0] VEC_BASE_MASK = 32'hFFFC_0000;
    localparam logic [31:0] TILE_CTL_RST = 32'h0000_0000;
    localparam logic [31:0] TILE_CTL_MASK = 32'h03FF_FF36;
    localparam logic [31:0] SEC_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] SEC_CFG_MASK = 32'h8000_5FB1;
    localparam logic [31:0] RO_CTL_RST = 32'h0000_0000;
    localparam logic [31:0] RO_CTL_MASK = 32'h0000_0003;

    // =====================================================================
    // field positions
    // =====================================================================
    localparam int TC_TXDLY_LSB = 18;
    localparam int TC_TXDLY_W = 8;
    localparam int TC_TXDIV_LSB = 9;
    localparam int TC_TXDIV_W = 9;
    localparam int TC_RGMII_EN = 8;
    localparam int TC_LP_DYN = 5;
    localparam int TC_LP_DIV_EN = 4;
    localparam int TC_UTMI_SEL = 2;
    localparam int TC_ULPI_EN = 1;
    localparam int SEC_WR_DIS = 31;
    localparam int SEC_DBG_DIS = 14;
    localparam int SEC_OTP_LOCK_ALL = 12;
    localparam int SEC_SECT_LSB = 8;
    localparam int SEC_OTP_REDUND = 7;
    localparam int SEC_BOOT_OTP = 5;
    localparam int SEC_JTAG_CFG_BLK = 4;
    localparam int SEC_TAP_DIS = 0;
    localparam int RO_CORE_EN = 1;
    localparam int RO_PERI_EN = 0;
    localparam int VEC_SPLIT = 16;
    localparam int RO_CNT_W = 16;
    localparam int NUM_RO = 4;
    localparam int TX_DLY_DEPTH = 256;

    // =====================================================================
    // carriers
    // =====================================================================
    typedef struct packed {
        logic valid;
        logic we;
        logic [15:0] resource;
        logic [31:0] wdata;
    } ps_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } ps_rsp_t;

    typedef struct packed {
        logic [7:0] proc_num;
        logic boot_ovr;
        logic core1_off;
        logic no_otp_poll;
        logic from_ram;
        logic from_jtag;
        logic [1:0] pll_mode;
    } boot_strap_t;

    typedef struct packed {
        logic ctl;
        logic [3:0] data;
    } rgmii_tx_t;

endpackage : psr_pkg

// ### hw/ring_osc_counter.sv
`timescale 1ns/1ps
module ring_osc_counter import psr_pkg::*; #(
    parameter int CNT_W = RO_CNT_W
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic osc_i,
    output logic [CNT_W-1:0] count_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } osc_sync_t;

    osc_sync_t state;
    osc_sync_t next_state;
    logic [CNT_W-1:0] count = '0; // power-up value only, system reset leaves it alone

    // =====================================================================
    // oscillator sampling
    // =====================================================================
    // two-stage sync of a free-running edge source, then edge detect on stage two
    always_comb begin
        next_state.s1 = osc_i;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // =====================================================================
    // count, deliberately without reset
    // =====================================================================
    // survives system reset; stable once the oscillator is stopped
    always_ff @(posedge mclk_i) begin
        if (state.s2 && !state.s3) begin
            count <= count + CNT_W'(1);
        end
    end

    assign count_o = count;

endmodule : ring_osc_counter

// ### hw/proc_status_regs.sv
`timescale 1ns/1ps
module proc_status_regs import psr_pkg::*; #(
    parameter int DLY_DEPTH = TX_DLY_DEPTH
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire ps_req_t ps_req_i,
    output ps_rsp_t ps_rsp_o,
    input wire logic event_take_i,
    input wire logic [15:0] event_vector_i,
    output logic [31:0] vector_addr_o,
    output logic vector_valid_o,
    input wire logic all_paused_i,
    output logic lp_div_en_o,
    input wire rgmii_tx_t rgmii_tx_i,
    output rgmii_tx_t rgmii_tx_o,
    output logic rgmii_txclk_o,
    output logic rgmii_en_o,
    output logic utmi_sel_o,
    output logic ulpi_en_o,
    output logic [31:0] ram_base_o,
    input wire boot_strap_t boot_strap_i,
    input wire logic otp_load_i,
    input wire logic [31:0] otp_sec_word_i,
    output logic dbg_disable_o,
    output logic jtag_cfg_block_o,
    output logic tap_disable_o,
    output logic otp_lock_all_o,
    output logic [3:0] otp_sector_lock_o,
    output logic otp_redund_o,
    output logic boot_from_otp_o,
    input wire logic [NUM_RO-1:0] ro_osc_i,
    output logic ro_core_en_o,
    output logic ro_peri_en_o
);

    typedef struct packed {
        logic [31:0] ram_base;
        logic [31:0] vec_base;
        logic [31:0] tile_ctl;
        logic [31:0] sec_cfg;
        logic [31:0] ro_ctl;
        boot_strap_t boot_s1;
        boot_strap_t boot_s2;
        ps_rsp_t rsp;
        logic [31:0] vec_addr;
        logic vec_valid;
        logic lp_div_en;
        logic [TC_TXDIV_W-1:0] txclk_cnt;
        logic txclk;
        logic [7:0] tx_wp;
        rgmii_tx_t tx_out;
    } psr_state_t;

    psr_state_t state;
    psr_state_t next_state;
    rgmii_tx_t tx_mem [0:DLY_DEPTH-1];
    logic [RO_CNT_W-1:0] ro_count [0:NUM_RO-1];
    logic [7:0] req_reg;
    logic req_hit;
    logic req_wr;
    logic [TC_TXDLY_W-1:0] tx_dly;
    logic [TC_TXDIV_W-1:0] tx_div;
    logic [7:0] tx_rp;
    logic [31:0] boot_word;
    logic [31:0] rd_word;
    logic rd_known;
    localparam int PTR_W = $clog2(DLY_DEPTH); // pointers wrap at the storage depth

    // =====================================================================
    // request decode
    // =====================================================================
    // register number sits above the resource type byte
    assign req_reg = ps_req_i.resource[15:8];
    assign req_hit = ps_req_i.valid && (ps_req_i.resource[7:0] == RES_TYPE_PS);
    assign req_wr = req_hit && ps_req_i.we;
    assign tx_dly = state.tile_ctl[TC_TXDLY_LSB +: TC_TXDLY_W];
    assign tx_div = state.tile_ctl[TC_TXDIV_LSB +: TC_TXDIV_W];
    assign tx_rp = state.tx_wp - tx_dly;

    // boot strap fields packed into their register positions
    always_comb begin
        boot_word = '0;
        boot_word[23:16] = state.boot_s2.proc_num;
        boot_word[8] = state.boot_s2.boot_ovr;
        boot_word[5] = state.boot_s2.core1_off;
        boot_word[4] = state.boot_s2.no_otp_poll;
        boot_word[3] = state.boot_s2.from_ram;
        boot_word[2] = state.boot_s2.from_jtag;
        boot_word[1:0] = state.boot_s2.pll_mode;
    end

    // read mux; unknown numbers answer with error
    always_comb begin
        rd_word = '0;
        rd_known = 1'b1;
        unique case (req_reg)
            REG_RAM_BASE: rd_word = state.ram_base;
            REG_VEC_BASE: rd_word = state.vec_base;
            REG_TILE_CTL: rd_word = state.tile_ctl;
            REG_BOOT_STAT: rd_word = boot_word;
            REG_SEC_CFG: rd_word = state.sec_cfg;
            REG_RO_CTL: rd_word = state.ro_ctl;
            REG_RO_CORE_CELL: rd_word = {16'h0000, ro_count[0]};
            REG_RO_CORE_WIRE: rd_word = {16'h0000, ro_count[1]};
            REG_RO_PERI_CELL: rd_word = {16'h0000, ro_count[2]};
            REG_RO_PERI_WIRE: rd_word = {16'h0000, ro_count[3]};
            default: rd_known = 1'b0;
        endcase
    end

    // =====================================================================
    // next state
    // =====================================================================
    always_comb begin
        next_state = state;

        // strap pins pass two flops before use
        next_state.boot_s1 = boot_strap_i;
        next_state.boot_s2 = state.boot_s1;

        // answer one cycle after the request
        next_state.rsp.ack = req_hit || ps_req_i.valid;
        next_state.rsp.err = ps_req_i.valid && !(req_hit && rd_known);
        next_state.rsp.rdata = (req_hit && !ps_req_i.we) ? rd_word : 32'h0000_0000;

        // register writes, reserved bits masked off
        if (req_wr) begin
            unique case (req_reg)
                REG_RAM_BASE: next_state.ram_base = ps_req_i.wdata & RAM_BASE_MASK;
                REG_VEC_BASE: next_state.vec_base = ps_req_i.wdata & VEC_BASE_MASK;
                REG_TILE_CTL: next_state.tile_ctl = ps_req_i.wdata & TILE_CTL_MASK;
                REG_SEC_CFG: begin
                    if (!state.sec_cfg[SEC_WR_DIS]) begin
                        next_state.sec_cfg = ps_req_i.wdata & SEC_CFG_MASK;
                    end
                end
                REG_RO_CTL: next_state.ro_ctl = ps_req_i.wdata & RO_CTL_MASK;
                default: next_state.rsp.ack = 1'b1;
            endcase
        end

        // otp copy wins over a software write in the same cycle
        if (otp_load_i) begin
            next_state.sec_cfg = otp_sec_word_i & SEC_CFG_MASK;
        end

        // event destination address
        next_state.vec_valid = event_take_i;
        if (event_take_i) begin
            next_state.vec_addr = {state.vec_base[31:VEC_SPLIT], event_vector_i};
        end

        // low-power divider, static or only while all threads pause
        next_state.lp_div_en = state.tile_ctl[TC_LP_DIV_EN] &&
            (!state.tile_ctl[TC_LP_DYN] || all_paused_i);

        // transmit clock generator, ratio is divider value plus one
        if (!state.tile_ctl[TC_RGMII_EN]) begin
            next_state.txclk_cnt = '0;
            next_state.txclk = 1'b0;
        end else begin
            if (state.txclk_cnt >= tx_div) begin
                next_state.txclk_cnt = '0;
            end else begin
                next_state.txclk_cnt = state.txclk_cnt + TC_TXDIV_W'(1);
            end
            if (state.txclk_cnt == tx_div) begin
                next_state.txclk = 1'b1;
            end else if (state.txclk_cnt == (tx_div >> 1)) begin
                next_state.txclk = 1'b0;
            end
        end

        // transmit data delay line, latency is delay plus one
        next_state.tx_wp = state.tx_wp + 8'h01;
        if (tx_dly == '0) begin
            next_state.tx_out = rgmii_tx_i;
        end else begin
            next_state.tx_out = tx_mem[tx_rp[PTR_W-1:0]];
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= '0;
            state.ram_base <= RAM_BASE_RST;
            state.vec_base <= VEC_BASE_RST;
            state.tile_ctl <= TILE_CTL_RST;
            state.sec_cfg <= SEC_CFG_RST;
            state.ro_ctl <= RO_CTL_RST;
        end else begin
            state <= next_state;
        end
    end

    // delay storage, no reset needed
    always_ff @(posedge mclk_i) begin
        tx_mem[state.tx_wp[PTR_W-1:0]] <= rgmii_tx_i;
    end

    // =====================================================================
    // ring oscillator counters
    // =====================================================================
    // values stable for reading only after the oscillator stopped for a while
    for (genvar i = 0; i < NUM_RO; i++) begin : g_ro
        ring_osc_counter #(
            .CNT_W(RO_CNT_W)
        ) u_cnt (
            .mclk_i(mclk_i),
            .arst_n_i(arst_n_i),
            .osc_i(ro_osc_i[i]),
            .count_o(ro_count[i])
        );
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign ps_rsp_o = state.rsp;
    assign vector_addr_o = state.vec_addr;
    assign vector_valid_o = state.vec_valid;
    assign lp_div_en_o = state.lp_div_en;
    assign rgmii_tx_o = state.tx_out;
    assign rgmii_txclk_o = state.txclk;
    assign rgmii_en_o = state.tile_ctl[TC_RGMII_EN];
    assign utmi_sel_o = state.tile_ctl[TC_UTMI_SEL];
    assign ulpi_en_o = state.tile_ctl[TC_ULPI_EN];
    assign ram_base_o = state.ram_base;
    assign dbg_disable_o = state.sec_cfg[SEC_DBG_DIS];
    assign jtag_cfg_block_o = state.sec_cfg[SEC_JTAG_CFG_BLK];
    assign tap_disable_o = state.sec_cfg[SEC_TAP_DIS];
    assign otp_lock_all_o = state.sec_cfg[SEC_OTP_LOCK_ALL];
    assign otp_sector_lock_o = state.sec_cfg[SEC_SECT_LSB +: 4];
    assign otp_redund_o = state.sec_cfg[SEC_OTP_REDUND];
    assign boot_from_otp_o = state.sec_cfg[SEC_BOOT_OTP];
    assign ro_core_en_o = state.ro_ctl[RO_CORE_EN];
    assign ro_peri_en_o = state.ro_ctl[RO_PERI_EN];

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    logic wr_ram;
    logic wr_sec;
    logic rd_cell;
    assign wr_ram = req_wr && (req_reg == REG_RAM_BASE);
    assign wr_sec = req_wr && (req_reg == REG_SEC_CFG);
    assign rd_cell = req_hit && !ps_req_i.we && (req_reg == REG_RO_CORE_CELL);

    a_ram_base_reserved: assert property (ram_base_o[1:0] == 2'b00)
        else $error("ram base reserved bits set");
    a_ram_base_write: assert property (wr_ram |=> ram_base_o == ($past(ps_req_i.wdata) & RAM_BASE_MASK))
        else $error("ram base write lost");
    a_vector_form: assert property (event_take_i |=> vector_valid_o &&
        vector_addr_o[15:0] == $past(event_vector_i) && vector_addr_o[31:16] == $past(state.vec_base[31:16]))
        else $error("vector address wrong");
    a_txclk_rise: assert property (rgmii_en_o && state.txclk_cnt == tx_div |=> rgmii_txclk_o)
        else $error("tx clock did not rise");
    a_txclk_fall: assert property (rgmii_en_o && state.txclk_cnt == (tx_div >> 1) &&
        state.txclk_cnt != tx_div && $stable(state.tile_ctl) |=> !rgmii_txclk_o)
        else $error("tx clock did not fall");
    a_tx_no_delay: assert property (tx_dly == '0 |=> rgmii_tx_o == $past(rgmii_tx_i))
        else $error("tx data not passed through");
    a_lp_static_off: assert property (!state.tile_ctl[TC_LP_DIV_EN] |=> !lp_div_en_o)
        else $error("divider on while disabled");
    a_lp_dynamic: assert property (state.tile_ctl[TC_LP_DIV_EN] && state.tile_ctl[TC_LP_DYN] &&
        !all_paused_i |=> !lp_div_en_o)
        else $error("dynamic divider active while running");
    a_sec_locked: assert property (wr_sec && state.sec_cfg[SEC_WR_DIS] && !otp_load_i |=>
        $stable(state.sec_cfg))
        else $error("locked security register changed");
    a_unmapped_err: assert property (ps_req_i.valid && !req_hit |=> ps_rsp_o.ack && ps_rsp_o.err)
        else $error("unmapped access not refused");
    a_cell_read: assert property (rd_cell |=> ps_rsp_o.rdata == {16'h0000, $past(ro_count[0])})
        else $error("cell count readback wrong");
    a_boot_reserved: assert property (req_hit && !ps_req_i.we && req_reg == REG_BOOT_STAT |=>
        ps_rsp_o.rdata[31:24] == 8'h00 && ps_rsp_o.rdata[15:9] == 7'h00 && !ps_rsp_o.err)
        else $error("boot status reserved bits set");

    // reserved bits never hold a one
    a_vec_reserved: assert property (state.vec_base[17:0] == 18'h0_0000)
        else $error("vector base reserved bits set");
    a_tile_reserved: assert property ((state.tile_ctl & ~TILE_CTL_MASK) == 32'h0000_0000)
        else $error("tile control reserved bits set");
    a_sec_reserved: assert property ((state.sec_cfg & ~SEC_CFG_MASK) == 32'h0000_0000)
        else $error("security reserved bits set");
    a_ro_ctl_reserved: assert property ((state.ro_ctl & ~RO_CTL_MASK) == 32'h0000_0000)
        else $error("ring control reserved bits set");

    // answer pulse follows each request, writes return no data
    a_rsp_pulse: assert property (ps_rsp_o.ack == $past(ps_req_i.valid))
        else $error("answer pulse missing or extra");
    a_err_with_ack: assert property (ps_rsp_o.err |-> ps_rsp_o.ack)
        else $error("error without answer");
    a_write_no_data: assert property (req_wr |=> ps_rsp_o.rdata == 32'h0000_0000)
        else $error("write returned data");
    a_tile_write: assert property (req_wr && req_reg == REG_TILE_CTL |=>
        state.tile_ctl == ($past(ps_req_i.wdata) & TILE_CTL_MASK))
        else $error("tile control write lost");

    // security register loads and open writes
    a_otp_copy: assert property (otp_load_i |=> state.sec_cfg == ($past(otp_sec_word_i) & SEC_CFG_MASK))
        else $error("security copy not loaded");
    a_sec_write_open: assert property (wr_sec && !state.sec_cfg[SEC_WR_DIS] && !otp_load_i |=>
        state.sec_cfg == ($past(ps_req_i.wdata) & SEC_CFG_MASK))
        else $error("open security write lost");

    // static divider and a disabled transmit port
    a_lp_static_on: assert property (state.tile_ctl[TC_LP_DIV_EN] && !state.tile_ctl[TC_LP_DYN] |=> lp_div_en_o)
        else $error("static divider not active");
    a_txclk_off: assert property (!rgmii_en_o |=> !rgmii_txclk_o)
        else $error("tx clock runs while port disabled");

    c_event_taken: cover property (event_take_i ##1 vector_valid_o);
    c_locked_write: cover property (wr_sec && state.sec_cfg[SEC_WR_DIS]);
    c_txclk_toggle: cover property (rgmii_txclk_o ##1 !rgmii_txclk_o);
    c_unmapped: cover property (ps_req_i.valid && !req_hit);
    c_otp_over_lock: cover property (otp_load_i && state.sec_cfg[SEC_WR_DIS]);

endmodule : proc_status_regs

// ### dv/core_model.sv
`timescale 1ns/1ps
// =====================================================================
// core side of the status register port
// =====================================================================
module core_model import psr_pkg::*; (
    input wire logic mclk_i,
    input wire ps_rsp_t ps_rsp_i,
    output ps_req_t ps_req_o
);
    initial begin
        ps_req_o = '0;
    end

    // one request per call, answer taken half a cycle after the take edge
    task automatic access(input logic we, input logic [7:0] num, input logic [7:0] typ,
                          input logic [31:0] wdata, output ps_rsp_t rsp);
        @(negedge mclk_i);
        ps_req_o.valid = 1'b1;
        ps_req_o.we = we;
        ps_req_o.resource = {num, typ};
        ps_req_o.wdata = wdata;
        @(negedge mclk_i);
        rsp = ps_rsp_i;
        // released fields show a changed value, not the last one
        ps_req_o.valid = 1'b0;
        ps_req_o.resource = ~ps_req_o.resource;
        ps_req_o.wdata = ~wdata;
    endtask : access
endmodule : core_model

// ### dv/proc_status_regs_test.sv
`timescale 1ns/1ps
module proc_status_regs_test import psr_pkg::*;;
    typedef struct packed {logic we; logic [7:0] num; logic [31:0] wd; logic [31:0] rd; logic er;} row_t;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    ps_req_t ps_req;
    ps_rsp_t ps_rsp;
    ps_rsp_t rs;
    logic event_take = 1'b0;
    logic [15:0] event_vector = 16'h0000;
    logic [31:0] vector_addr;
    logic vector_valid;
    logic all_paused = 1'b0;
    logic lp_div_en;
    rgmii_tx_t tx_in = '0;
    rgmii_tx_t tx_out;
    logic txclk, rgmii_en, utmi_sel, ulpi_en, dbg_dis, jtag_blk, tap_dis, lock_all, redund, boot_otp;
    logic ro_core_en, ro_peri_en;
    logic [31:0] ram_base;
    logic [3:0] sect_lock;
    logic otp_load = 1'b0;
    logic [31:0] otp_word = 32'h0000_0000;
    logic [3:0] osc = 4'h0;
    boot_strap_t strap = '{8'h5A, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'b10};
    int n_errors = 0;
    int check_count = 0;
    int highs, rises;
    logic prev_clk;
    logic [4:0] hist [0:63];
    logic [31:0] a7, a8, c7, c8;
    row_t rows [21] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0004_0000, 1'b0}, '{1'b1, 8'h00, 32'hFFFF_FFFF, 32'h0, 1'b0},
        '{1'b0, 8'h00, 32'h0, 32'hFFFF_FFFC, 1'b0}, '{1'b1, 8'h01, 32'hFFFF_FFFF, 32'h0, 1'b0},
        '{1'b0, 8'h01, 32'h0, 32'hFFFC_0000, 1'b0}, '{1'b1, 8'h02, 32'hFFFF_FFFF, 32'h0, 1'b0},
        '{1'b0, 8'h02, 32'h0, 32'h03FF_FF36, 1'b0}, '{1'b1, 8'h03, 32'hFFFF_FFFF, 32'h0, 1'b0},
        '{1'b0, 8'h03, 32'h0, 32'h005A_0116, 1'b0}, '{1'b1, 8'h05, 32'h7FFF_FFFF, 32'h0, 1'b0},
        '{1'b0, 8'h05, 32'h0, 32'h0000_5FB1, 1'b0}, '{1'b1, 8'h05, 32'h8000_0000, 32'h0, 1'b0},
        '{1'b1, 8'h05, 32'h0000_5FB1, 32'h0, 1'b0}, '{1'b0, 8'h05, 32'h0, 32'h8000_0000, 1'b0},
        '{1'b1, 8'h06, 32'hFFFF_FFFF, 32'h0, 1'b0}, '{1'b0, 8'h06, 32'h0, 32'h0000_0003, 1'b0},
        '{1'b0, 8'h04, 32'h0, 32'h0, 1'b1}, '{1'b0, 8'h0B, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h04, 32'h1, 32'h0, 1'b1}, '{1'b0, 8'h09, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h0A, 32'h0, 32'h0, 1'b0}};

    always #4 mclk_i = ~mclk_i;

    core_model core_u (.mclk_i(mclk_i), .ps_rsp_i(ps_rsp), .ps_req_o(ps_req));

    proc_status_regs #(.DLY_DEPTH(16)) dut_u (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ps_req_i(ps_req), .ps_rsp_o(ps_rsp),
        .event_take_i(event_take), .event_vector_i(event_vector), .vector_addr_o(vector_addr),
        .vector_valid_o(vector_valid), .all_paused_i(all_paused), .lp_div_en_o(lp_div_en),
        .rgmii_tx_i(tx_in), .rgmii_tx_o(tx_out), .rgmii_txclk_o(txclk), .rgmii_en_o(rgmii_en),
        .utmi_sel_o(utmi_sel), .ulpi_en_o(ulpi_en), .ram_base_o(ram_base), .boot_strap_i(strap),
        .otp_load_i(otp_load), .otp_sec_word_i(otp_word), .dbg_disable_o(dbg_dis),
        .jtag_cfg_block_o(jtag_blk), .tap_disable_o(tap_dis), .otp_lock_all_o(lock_all),
        .otp_sector_lock_o(sect_lock), .otp_redund_o(redund), .boot_from_otp_o(boot_otp),
        .ro_osc_i(osc), .ro_core_en_o(ro_core_en), .ro_peri_en_o(ro_peri_en));

    // =====================================================================
    // helpers
    // =====================================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic acc(input logic we, input logic [7:0] num, input logic [31:0] wd);
        core_u.access(we, num, RES_TYPE_PS, wd, rs);
        check("ack", 32'(rs.ack), 32'h1);
    endtask : acc

    // osc[0] gets n rising edges, osc[1] half of them, slow against the core clock
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk_i);
            osc = {2'b00, i[0], 1'b1};
            repeat (2) @(negedge mclk_i);
            osc = 4'h0;
            repeat (2) @(negedge mclk_i);
        end
        repeat (10) @(negedge mclk_i);
    endtask : burst

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // watchdog well beyond the length of all tests
    initial begin
        #(20000 * 8);
        n_errors++;
        stop_test();
    end

    // =====================================================================
    // tests
    // =====================================================================
    initial begin
        repeat (2) @(negedge mclk_i);
        arst_n_i = 1'b1;
        foreach (rows[i]) begin
            acc(rows[i].we, rows[i].num, rows[i].wd);
            check($sformatf("row %0d data", i), rs.rdata, rows[i].rd);
            check($sformatf("row %0d err", i), 32'(rs.err), 32'(rows[i].er));
        end
        check("ctl pins", {ram_base[3:0], rgmii_en, utmi_sel, ulpi_en, ro_core_en, ro_peri_en}, 32'h19F);
        core_u.access(1'b0, 8'h00, 8'h0D, 32'h0, rs);
        check("bad type", {rs.err, rs.rdata[30:0]}, 32'h8000_0000);
        $display("test table done");
        // otp copy overrides the lock
        @(negedge mclk_i);
        otp_word = 32'h0000_4A11;
        otp_load = 1'b1;
        @(negedge mclk_i);
        otp_load = 1'b0;
        check("sec pins", {dbg_dis, jtag_blk, tap_dis, lock_all, sect_lock, redund, boot_otp}, 32'h3A8);
        acc(1'b0, 8'h05, 32'h0);
        check("sec copy", rs.rdata, 32'h0000_4A11);
        $display("test otp done");
        // back to back events
        acc(1'b1, 8'h01, 32'h1234_0000);
        event_take = 1'b1;
        event_vector = 16'h5678;
        @(negedge mclk_i);
        check("vector 1", {vector_valid, vector_addr[30:0]}, 32'h9234_5678);
        event_vector = 16'h0001;
        @(negedge mclk_i);
        event_take = 1'b0;
        check("vector 2", {vector_valid, vector_addr[30:0]}, 32'h9234_0001);
        @(negedge mclk_i);
        check("vector hold", {vector_valid, vector_addr[30:0]}, 32'h1234_0001);
        $display("test event done");
        // low-power divider, dynamic then static, transmit port off
        acc(1'b1, 8'h02, 32'h0000_0030);
        @(negedge mclk_i);
        check("lp dyn run", {txclk, rgmii_en, lp_div_en}, 32'h0);
        all_paused = 1'b1;
        @(negedge mclk_i);
        check("lp dyn paused", 32'(lp_div_en), 32'h1);
        all_paused = 1'b0;
        acc(1'b1, 8'h02, 32'h0000_0010);
        @(negedge mclk_i);
        check("lp static", 32'(lp_div_en), 32'h1);
        $display("test lowpower done");
        // delay 3, ratio 4 written as 3
        acc(1'b1, 8'h02, 32'h000C_0700);
        highs = 0;
        rises = 0;
        for (int k = 0; k < 40; k++) begin
            @(negedge mclk_i);
            if (k >= 8) begin
                check("tx delay", 32'(tx_out), 32'(hist[k - 4]));
            end
            if (k >= 8 && k < 24) begin
                highs += 32'(txclk);
                rises += 32'(txclk && !prev_clk);
            end
            prev_clk = txclk;
            hist[k] = 5'(k);
            tx_in = 5'(k);
        end
        check("txclk high", 32'(highs), 32'h8);
        check("txclk rises", 32'(rises), 32'h4);
        $display("test rgmii done");
        // ring counters survive reset
        acc(1'b1, 8'h06, 32'h0000_0003);
        burst(4);
        acc(1'b0, 8'h07, 32'h0);
        a7 = rs.rdata;
        acc(1'b0, 8'h08, 32'h0);
        a8 = rs.rdata;
        arst_n_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        arst_n_i = 1'b1;
        check("reset base", ram_base, 32'h0004_0000);
        check("reset ro en", 32'({ro_core_en, ro_peri_en}), 32'h0);
        acc(1'b0, 8'h07, 32'h0);
        check("cell kept", rs.rdata, a7);
        acc(1'b1, 8'h06, 32'h0000_0002);
        burst(4);
        acc(1'b0, 8'h07, 32'h0);
        c7 = rs.rdata;
        acc(1'b0, 8'h08, 32'h0);
        c8 = rs.rdata;
        check("cell count", {c7[31:16], 16'(c7[15:0] - a7[15:0])}, 32'h4);
        check("wire count", {c8[31:16], 16'(c8[15:0] - a8[15:0])}, 32'h2);
        $display("test ring done");
        stop_test();
    end
endmodule : proc_status_regs_test
